/* File: rtl/mpm_phase_counter.v */
// Purpose: per-phase threshold crossing counter
// Assumes: hit_i is a one-cycle pulse per crossing
// Notes: saturates; clear wins but keeps a same-cycle hit
`timescale 1ns/100ps
`default_nettype none
module mpm_phase_counter #(
   parameter W = 6
) (
   input wire ref_clk_i,
   input wire reset_i,
   input wire clk_en_i,
   input wire clear_i,
   input wire hit_i,
   input wire [W-1:0] limit_i,
   output reg reached_o
);
   reg [W-1:0] count_r;
   reg [W-1:0] count_nxt;

   always @* begin
      count_nxt = count_r;
      if (clear_i) begin
         count_nxt = {{(W-1){1'b0}}, hit_i};
      end else if (hit_i && (count_r != {W{1'b1}})) begin
         count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         count_r <= {W{1'b0}};
         reached_o <= 1'b0;
      end else if (clk_en_i) begin
         count_r <= count_nxt;
         reached_o <= (count_nxt >= limit_i);
      end
   end
endmodule // mpm_phase_counter
`default_nettype wire

/* File: rtl/mpm_regs.vh */
// Purpose: constants for the metering power mode sequencer
// Assumes: 200 MHz reference clock
// Notes: mode codes are the pin pair {high_mode_pin, low_mode_pin}
`ifndef MPM_REGS_VH
`define MPM_REGS_VH

`define MPM_MODE_REDUCED 2'b00
`define MPM_MODE_NORMAL 2'b01
`define MPM_MODE_LOW_POWER 2'b10
`define MPM_MODE_SLEEP 2'b11

// threshold register: threshold level [2:0], line period field [7:3]
`define MPM_THR_RESET 8'h07
`define MPM_LINE_LSB 3
`define MPM_LINE_MSB 7
// lock configuration register: two-wire lock bit
`define MPM_LOCK_RESET 8'h00
`define MPM_LOCK_TWO_WIRE_BIT 1

`define MPM_CLK_MHZ 200
// measurement window unit 0.02 s
`define MPM_WIN_UNIT_MS 20
`define MPM_WIN_UNIT_CYC (`MPM_WIN_UNIT_MS * 1000 * `MPM_CLK_MHZ)
// least low time of the reset pin
`define MPM_HWRST_MIN_US 10
`define MPM_HWRST_MIN_CYC (`MPM_HWRST_MIN_US * `MPM_CLK_MHZ)
// internal reset transition length in cycles
`define MPM_TRANS_CYC 64
// falling edges of port select that pick the four-wire port
`define MPM_FOUR_WIRE_EDGES 3

`endif

/* File: rtl/mpm_sequencer.v */
// Purpose: power mode sequencer of a polyphase metering device
// Assumes: mode, reset and port-select pins are asynchronous; other inputs share ref_clk_i
// Notes: status outputs are registered one cycle after the state they show
//
// Summary of operation
// - mode pins {high,low}: 01 normal, 00 reduced, 10 low power, 11 sleep.
// - low power counts crossings per phase over 0.02*(line+1) s windows.
// - normal to reduced starts mean-absolute computation at once, no interrupt.
// - low power keeps both serial ports off.
// - quiet interrupt low at window end when no phase reached the limit.
// - active interrupt low at window end when any phase reached the limit.
// - sleep shuts down most circuits.
// - sleep keeps both serial ports and the capture port off.
// - hardware reset in normal restores all defaults, two-wire port, DSP idle.
// - software reset keeps threshold, lock and locked port; DSP idle.
// - other modes keep threshold and lock registers; others unavailable.
// - reduced computes mean-absolute currents, serial port limited.
// - low power compares phases to threshold and raises quiet or active.
// - entry to normal ends with reset done set and active interrupt low.
// - reduced entry from low power or sleep pulls active interrupt low.
`timescale 1ns/100ps
`default_nettype none
`include "mpm_regs.vh"
module mpm_sequencer #(
   parameter WIN_UNIT_CYC = `MPM_WIN_UNIT_CYC,
   parameter HWRST_MIN_CYC = `MPM_HWRST_MIN_CYC,
   parameter TRANS_CYC = `MPM_TRANS_CYC
) (
   input wire ref_clk_i,
   input wire reset_i,
   input wire clk_en_i,
   input wire low_mode_pin_i,
   input wire high_mode_pin_i,
   input wire reset_pin_n_i,
   input wire port_select_pin_i,
   input wire sw_reset_i,
   input wire dsp_run_i,
   input wire dsp_stop_i,
   input wire capture_enable_bit_i,
   input wire thr_wr_i,
   input wire [7:0] thr_wdata_i,
   input wire lock_wr_i,
   input wire [7:0] lock_wdata_i,
   input wire reset_done_clr_i,
   input wire quiet_irq_clr_i,
   input wire [2:0] phase_over_i,
   output reg [1:0] mode_o,
   output reg regs_avail_o,
   output reg two_wire_en_o,
   output reg four_wire_en_o,
   output reg serial_limited_o,
   output reg capture_port_en_o,
   output reg circuits_on_o,
   output reg lp_compare_o,
   output reg mav_en_o,
   output reg mav_ready_o,
   output reg dsp_idle_o,
   output reg defaults_load_o,
   output reg reset_done_o,
   output reg quiet_irq_n_o,
   output reg active_irq_n_o,
   output reg [7:0] threshold_o,
   output reg [7:0] lock_cfg_o
);
   localparam [31:0] WIN_LAST_W = WIN_UNIT_CYC - 1;
   localparam [31:0] HW_MIN_W = HWRST_MIN_CYC;
   localparam [31:0] TRANS_LAST_W = TRANS_CYC - 1;
   localparam [31:0] EDGES_W = `MPM_FOUR_WIRE_EDGES;
   localparam [21:0] WIN_LAST = WIN_LAST_W[21:0];
   localparam [11:0] HW_MIN = HW_MIN_W[11:0];
   localparam [15:0] TRANS_LAST = TRANS_LAST_W[15:0];
   localparam [1:0] EDGES = EDGES_W[1:0];

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   reg [1:0] pin_s1_r, pin_s2_r, pin_prev_r;
   reg rst_s1_r, rst_s2_r, rst_prev_r;
   reg sel_s1_r, sel_s2_r, sel_prev_r;

   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         pin_s1_r <= `MPM_MODE_SLEEP;
         pin_s2_r <= `MPM_MODE_SLEEP;
         pin_prev_r <= `MPM_MODE_SLEEP;
         rst_s1_r <= 1'b1;
         rst_s2_r <= 1'b1;
         rst_prev_r <= 1'b1;
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
         sel_prev_r <= 1'b1;
      end else if (clk_en_i) begin
         pin_s1_r <= {high_mode_pin_i, low_mode_pin_i};
         pin_s2_r <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
         rst_s1_r <= reset_pin_n_i;
         rst_s2_r <= rst_s1_r;
         rst_prev_r <= rst_s2_r;
         sel_s1_r <= port_select_pin_i;
         sel_s2_r <= sel_s1_r;
         sel_prev_r <= sel_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg [1:0] mode_r;
   reg busy_r;
   reg [15:0] trans_cnt_r;
   reg [11:0] hw_low_cnt_r;
   reg [7:0] thr_r, lock_r;
   reg locked_r, four_wire_r;
   reg [1:0] edge_cnt_r;
   reg dsp_idle_r, defload_r, done_r, quiet_n_r, active_n_r, mav_ready_r;
   reg [21:0] win_tick_r;
   reg [4:0] win_unit_r;
   wire [2:0] reached;

   wire is_normal = (mode_r == `MPM_MODE_NORMAL);
   wire is_reduced = (mode_r == `MPM_MODE_REDUCED);
   wire is_lp = (mode_r == `MPM_MODE_LOW_POWER);
   wire mode_chg = (pin_s2_r == pin_prev_r) && (pin_s2_r != mode_r);
   wire [4:0] line = thr_r[`MPM_LINE_MSB:`MPM_LINE_LSB];
   wire [5:0] limit = {1'b0, line} + 6'h01;
   wire to_normal = mode_chg && (pin_s2_r == `MPM_MODE_NORMAL);
   wire to_reduced = mode_chg && (pin_s2_r == `MPM_MODE_REDUCED);
   wire to_lp = mode_chg && (pin_s2_r == `MPM_MODE_LOW_POWER);
   // reset pin only counts in normal mode
   wire hw_start = is_normal && !mode_chg && rst_s2_r && !rst_prev_r &&
                   (hw_low_cnt_r >= HW_MIN);
   wire sw_start = is_normal && !mode_chg && !busy_r && sw_reset_i;
   wire trans_end = busy_r && (trans_cnt_r == TRANS_LAST);
   wire wr_ok = is_normal && !busy_r && !mode_chg;
   wire lp_run = is_lp && !mode_chg;
   wire win_end = lp_run && (win_tick_r == WIN_LAST) && (win_unit_r == line);
   wire win_clear = !lp_run || win_end;
   wire any_reached = |reached;
   wire sel_fall = sel_prev_r && !sel_s2_r;
   wire mav_irq = to_reduced && !is_normal;
   wire active_set = trans_end || mav_irq || (win_end && any_reached);
   wire quiet_set = win_end && !any_reached;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_phase
         mpm_phase_counter #(
            .W(6)
         ) u_cnt (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .clk_en_i(clk_en_i),
            .clear_i(win_clear),
            .hit_i(lp_run && phase_over_i[g]),
            .limit_i(limit),
            .reached_o(reached[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // mode, transition and register retention
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         mode_r <= `MPM_MODE_SLEEP;
         busy_r <= 1'b0;
         trans_cnt_r <= 16'h0000;
         hw_low_cnt_r <= 12'h000;
         thr_r <= `MPM_THR_RESET;
         lock_r <= `MPM_LOCK_RESET;
         locked_r <= 1'b0;
         four_wire_r <= 1'b0;
         edge_cnt_r <= 2'h0;
         dsp_idle_r <= 1'b1;
         defload_r <= 1'b0;
         done_r <= 1'b0;
         mav_ready_r <= 1'b0;
         win_tick_r <= 22'h000000;
         win_unit_r <= 5'h00;
      end else if (clk_en_i) begin
         defload_r <= 1'b0;
         if (mode_chg) begin
            mode_r <= pin_s2_r;
         end
         if (is_normal && !rst_s2_r) begin
            if (hw_low_cnt_r != 12'hfff) begin
               hw_low_cnt_r <= hw_low_cnt_r + 12'h001;
            end
         end else begin
            hw_low_cnt_r <= 12'h000;
         end
         if (hw_start) begin
            thr_r <= `MPM_THR_RESET;
            lock_r <= `MPM_LOCK_RESET;
            locked_r <= 1'b0;
            four_wire_r <= 1'b0;
            edge_cnt_r <= 2'h0;
         end else if (sw_start || to_normal) begin
            if (!locked_r) begin
               four_wire_r <= 1'b0;
               edge_cnt_r <= 2'h0;
            end
         end else if (wr_ok) begin
            if (thr_wr_i) begin
               thr_r <= thr_wdata_i;
            end
            if (lock_wr_i) begin
               lock_r <= lock_wdata_i;
               if (four_wire_r || lock_wdata_i[`MPM_LOCK_TWO_WIRE_BIT]) begin
                  locked_r <= 1'b1;
               end
            end
            if (sel_fall && !locked_r && !four_wire_r) begin
               if (edge_cnt_r == EDGES - 2'h1) begin
                  four_wire_r <= 1'b1;
               end
               edge_cnt_r <= edge_cnt_r + 2'h1;
            end
         end
         if (hw_start || sw_start || to_normal) begin
            busy_r <= 1'b1;
            trans_cnt_r <= 16'h0000;
            done_r <= 1'b0;
            dsp_idle_r <= 1'b1;
            defload_r <= 1'b1;
         end else if (busy_r) begin
            trans_cnt_r <= trans_cnt_r + 16'h0001;
            if (trans_end) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end else if (done_r && reset_done_clr_i) begin
            done_r <= 1'b0;
         end
         if (mode_chg && !to_normal) begin
            busy_r <= 1'b0;
         end
         if (wr_ok && dsp_run_i && !sw_start && !hw_start) begin
            dsp_idle_r <= 1'b0;
         end else if (dsp_stop_i || (mode_chg && !to_normal)) begin
            dsp_idle_r <= 1'b1;
         end
         if (to_reduced) begin
            mav_ready_r <= 1'b1;
         end else if (mode_chg) begin
            mav_ready_r <= 1'b0;
         end
         if (win_clear) begin
            win_tick_r <= 22'h000000;
            win_unit_r <= 5'h00;
         end else if (win_tick_r == WIN_LAST) begin
            win_tick_r <= 22'h000000;
            win_unit_r <= win_unit_r + 5'h01;
         end else begin
            win_tick_r <= win_tick_r + 22'h000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pins, set wins over clear
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         quiet_n_r <= 1'b1;
         active_n_r <= 1'b1;
      end else if (clk_en_i) begin
         if (quiet_set) begin
            quiet_n_r <= 1'b0;
         end else if (quiet_irq_clr_i || to_lp) begin
            quiet_n_r <= 1'b1;
         end
         if (active_set) begin
            active_n_r <= 1'b0;
         end else if (reset_done_clr_i || to_lp) begin
            active_n_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always @(posedge ref_clk_i) begin
      if (reset_i) begin
         mode_o <= `MPM_MODE_SLEEP;
         regs_avail_o <= 1'b0;
         two_wire_en_o <= 1'b0;
         four_wire_en_o <= 1'b0;
         serial_limited_o <= 1'b0;
         capture_port_en_o <= 1'b0;
         circuits_on_o <= 1'b0;
         lp_compare_o <= 1'b0;
         mav_en_o <= 1'b0;
         mav_ready_o <= 1'b0;
         dsp_idle_o <= 1'b1;
         defaults_load_o <= 1'b0;
         reset_done_o <= 1'b0;
         quiet_irq_n_o <= 1'b1;
         active_irq_n_o <= 1'b1;
         threshold_o <= `MPM_THR_RESET;
         lock_cfg_o <= `MPM_LOCK_RESET;
      end else if (clk_en_i) begin
         mode_o <= mode_r;
         regs_avail_o <= is_normal && !busy_r;
         two_wire_en_o <= (is_normal || is_reduced) && !four_wire_r;
         four_wire_en_o <= (is_normal || is_reduced) && four_wire_r;
         serial_limited_o <= is_reduced;
         capture_port_en_o <= is_normal && !busy_r && capture_enable_bit_i;
         circuits_on_o <= (mode_r != `MPM_MODE_SLEEP);
         lp_compare_o <= is_lp;
         mav_en_o <= is_reduced;
         mav_ready_o <= mav_ready_r;
         dsp_idle_o <= dsp_idle_r;
         defaults_load_o <= defload_r;
         reset_done_o <= done_r;
         quiet_irq_n_o <= quiet_n_r;
         active_irq_n_o <= active_n_r;
         threshold_o <= thr_r;
         lock_cfg_o <= lock_r;
      end
   end
endmodule // mpm_sequencer
`default_nettype wire

/* File: test/mpm_host_model.sv */
// Purpose: host model that drives the two mode pins
// Assumes: bench requests arrive on ref_clk_i
// Notes: in auto it reacts to the low power result
`timescale 1ns/100ps
`default_nettype none
module mpm_host_model (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [1:0] req_mode_i,
   input wire logic auto_i,
   input wire logic lp_i,
   input wire logic quiet_irq_n_i,
   input wire logic active_irq_n_i,
   output logic low_mode_pin_o,
   output logic high_mode_pin_o
);
   // pull-ups give sleep at power-up
   logic [1:0] pins_r = 2'b11;
   assign {high_mode_pin_o, low_mode_pin_o} = pins_r;
   always @(posedge ref_clk_i) begin
      if (reset_i)
         pins_r <= 2'b11;
      else if (!auto_i)
         pins_r <= req_mode_i;
      else if (lp_i && !quiet_irq_n_i)
         pins_r <= 2'b11;
      else if (lp_i && !active_irq_n_i)
         pins_r <= 2'b00;
   end
endmodule // mpm_host_model
`default_nettype wire

/* File: test/mpm_sequencer_assertions.sv */
// Purpose: port checks of the power mode sequencer
// Assumes: one clock, synchronous reset
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
`default_nettype none
module mpm_sequencer_assertions (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [1:0] mode_o,
   input wire logic regs_avail_o,
   input wire logic two_wire_en_o,
   input wire logic four_wire_en_o,
   input wire logic capture_port_en_o,
   input wire logic circuits_on_o,
   input wire logic lp_compare_o,
   input wire logic mav_en_o,
   input wire logic mav_ready_o,
   input wire logic serial_limited_o,
   input wire logic reset_done_o,
   input wire logic quiet_irq_n_o,
   input wire logic active_irq_n_o,
   input wire logic [7:0] threshold_o,
   input wire logic [7:0] lock_cfg_o
);
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_from_normal;
      mode_o == 2'b00 && $past(mode_o) == 2'b01;
   endsequence
   sequence s_wake;
      mode_o == 2'b00 && $past(mode_o[1]);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_lp_ports_off: assert property (lp_compare_o |-> !two_wire_en_o && !four_wire_en_o)
      else $error("serial port on in low power");
   a_sleep_ports_off: assert property (mode_o == 2'b11
      |-> !(two_wire_en_o | four_wire_en_o | capture_port_en_o)) else $error("port on in sleep");
   a_sleep_dark: assert property (mode_o == 2'b11 |-> !circuits_on_o)
      else $error("circuits on in sleep");
   a_lp_compare_mode: assert property (lp_compare_o |-> mode_o == 2'b10)
      else $error("compare outside low power");
   a_mav_reduced: assert property (mav_en_o |-> mode_o == 2'b00 && serial_limited_o)
      else $error("mav outside reduced");
   a_regs_normal: assert property (regs_avail_o |-> mode_o == 2'b01)
      else $error("registers open outside normal");
   a_keep_regs: assert property (mode_o != 2'b01 && $past(mode_o) != 2'b01
      |=> $stable(threshold_o) && $stable(lock_cfg_o)) else $error("kept registers changed");
   a_done_irq: assert property ($rose(reset_done_o) |-> !active_irq_n_o)
      else $error("done without active irq");
   a_quiet_lp: assert property ($fell(quiet_irq_n_o) |-> $past(lp_compare_o))
      else $error("quiet irq outside low power");
   a_wake_irq: assert property (s_wake |-> ##[0:3] (!active_irq_n_o && mav_ready_o))
      else $error("no irq on reduced wake");
   a_normal_reduced: assert property (s_from_normal |-> ##[0:3] mav_ready_o)
      else $error("mav not ready from normal");
endmodule // mpm_sequencer_assertions
bind mpm_sequencer mpm_sequencer_assertions i_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .mode_o(mode_o), .regs_avail_o(regs_avail_o), .two_wire_en_o(two_wire_en_o),
   .four_wire_en_o(four_wire_en_o), .capture_port_en_o(capture_port_en_o),
   .circuits_on_o(circuits_on_o), .lp_compare_o(lp_compare_o), .mav_en_o(mav_en_o),
   .mav_ready_o(mav_ready_o), .serial_limited_o(serial_limited_o),
   .reset_done_o(reset_done_o), .quiet_irq_n_o(quiet_irq_n_o),
   .active_irq_n_o(active_irq_n_o), .threshold_o(threshold_o), .lock_cfg_o(lock_cfg_o));
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: self-checking bench of the power mode sequencer
// Assumes: shortened window, reset pin and transition counts
// Notes: expectations kept as integers in the bench
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module testbench;
   localparam int WU = 20;
   int n_mismatch = 0;
   int n_checks = 0;
   logic ref_clk_i = 0, reset_i = 1, clk_en_i = 1, aut = 0;
   logic reset_pin_n_i = 1, port_select_pin_i = 1;
   logic sw_reset_i = 0, dsp_run_i = 0, dsp_stop_i = 0, capture_enable_bit_i = 0;
   logic thr_wr_i = 0, lock_wr_i = 0, reset_done_clr_i = 0, quiet_irq_clr_i = 0;
   logic [7:0] thr_wdata_i = 0, lock_wdata_i = 0;
   logic [2:0] phase_over_i = 0;
   logic [1:0] req = 2'b11;
   wire low_mode_pin_i, high_mode_pin_i, regs_avail_o, two_wire_en_o, four_wire_en_o;
   wire serial_limited_o, capture_port_en_o, circuits_on_o, lp_compare_o, mav_en_o;
   wire mav_ready_o, dsp_idle_o, defaults_load_o, reset_done_o, quiet_irq_n_o, active_irq_n_o;
   wire [1:0] mode_o;
   wire [7:0] threshold_o, lock_cfg_o;
   mpm_sequencer #(.WIN_UNIT_CYC(WU), .HWRST_MIN_CYC(4), .TRANS_CYC(4)) i_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .low_mode_pin_i(low_mode_pin_i), .high_mode_pin_i(high_mode_pin_i),
      .reset_pin_n_i(reset_pin_n_i), .port_select_pin_i(port_select_pin_i),
      .sw_reset_i(sw_reset_i), .dsp_run_i(dsp_run_i), .dsp_stop_i(dsp_stop_i),
      .capture_enable_bit_i(capture_enable_bit_i), .thr_wr_i(thr_wr_i),
      .thr_wdata_i(thr_wdata_i), .lock_wr_i(lock_wr_i), .lock_wdata_i(lock_wdata_i),
      .reset_done_clr_i(reset_done_clr_i), .quiet_irq_clr_i(quiet_irq_clr_i),
      .phase_over_i(phase_over_i), .mode_o(mode_o), .regs_avail_o(regs_avail_o),
      .two_wire_en_o(two_wire_en_o), .four_wire_en_o(four_wire_en_o),
      .serial_limited_o(serial_limited_o), .capture_port_en_o(capture_port_en_o),
      .circuits_on_o(circuits_on_o), .lp_compare_o(lp_compare_o), .mav_en_o(mav_en_o),
      .mav_ready_o(mav_ready_o), .dsp_idle_o(dsp_idle_o), .defaults_load_o(defaults_load_o),
      .reset_done_o(reset_done_o), .quiet_irq_n_o(quiet_irq_n_o),
      .active_irq_n_o(active_irq_n_o), .threshold_o(threshold_o), .lock_cfg_o(lock_cfg_o));
   mpm_host_model i_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_mode_i(req),
      .auto_i(aut), .lp_i(lp_compare_o), .quiet_irq_n_i(quiet_irq_n_o),
      .active_irq_n_i(active_irq_n_o), .low_mode_pin_o(low_mode_pin_i),
      .high_mode_pin_o(high_mode_pin_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic wait_mode(input logic [1:0] m);
      for (int k = 0; k < 200 && mode_o !== m; k++)
         tick(1);
      `CHK("mode", m, mode_o)
   endtask
   task automatic go(input logic [1:0] m);
      dsp_stop_i <= 1;
      capture_enable_bit_i <= 0;
      reset_done_clr_i <= 1;
      quiet_irq_clr_i <= 1;
      req <= m;
      tick(1);
      dsp_stop_i <= 0;
      reset_done_clr_i <= 0;
      quiet_irq_clr_i <= 0;
      wait_mode(m);
   endtask
   task automatic wait_done;
      for (int k = 0; k < 40 && reset_done_o !== 1'b1; k++)
         tick(1);
      `CHK("active_interrupt", 1'b0, active_irq_n_o)
      `CHK("done", 1'b1, reset_done_o)
      reset_done_clr_i <= 1;
      tick(1);
      reset_done_clr_i <= 0;
      tick(1);
   endtask
   task automatic swr;
      sw_reset_i <= 1;
      tick(1);
      sw_reset_i <= 0;
      tick(2);
      `CHK("defaults", 1'b1, defaults_load_o)
      wait_done;
   endtask
   task automatic burst(input int n, input int p);
      quiet_irq_clr_i <= 1;
      reset_done_clr_i <= 1;
      tick(1);
      quiet_irq_clr_i <= 0;
      reset_done_clr_i <= 0;
      tick(2);
      for (int k = 0; k < n; k++) begin
         phase_over_i[p] <= 1;
         tick(1);
         phase_over_i <= 0;
         tick(1);
      end
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   initial begin
      #50000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      int l, lv, n, p, c, t, thr_e;
      void'($urandom(53421));
      l = $urandom % 4;
      lv = $urandom % 8;
      p = $urandom % 3;
      thr_e = l * 8 + lv;
      tick(2);
      reset_i <= 0;
      tick(2);
      `CHK("thr", 8'h07, threshold_o)
      go(2'b01);
      wait_done;
      `CHK("i2c", 1'b1, two_wire_en_o)
      `CHK("regs", 1'b1, regs_avail_o)
      thr_wr_i <= 1;
      thr_wdata_i <= thr_e[7:0];
      lock_wr_i <= 1;
      lock_wdata_i <= 8'h02;
      dsp_run_i <= 1;
      capture_enable_bit_i <= 1;
      req <= 2'b00;
      tick(1);
      thr_wr_i <= 0;
      lock_wr_i <= 0;
      dsp_run_i <= 0;
      req <= 2'b01;
      tick(8);
      `CHK("glitch", 2'b01, mode_o)
      `CHK("cap", 1'b1, capture_port_en_o)
      swr;
      `CHK("thr", thr_e, threshold_o)
      `CHK("lock", 8'h02, lock_cfg_o)
      `CHK("idle", 1'b1, dsp_idle_o)
      go(2'b00);
      tick(3);
      `CHK("active_interrupt", 1'b1, active_irq_n_o)
      `CHK("mav", 1'b1, mav_ready_o)
      `CHK("regs", 1'b0, regs_avail_o)
      `CHK("limited", 1'b1, serial_limited_o)
      `CHK("mav_en", 1'b1, mav_en_o)
      go(2'b10);
      for (c = 0; c < 4; c++) begin
         n = (c == 1) ? l + 1 : (c == 2) ? l : (c == 3) ? $urandom % (l + 2) : 0;
         burst(n, p);
         for (t = 3 + 2 * n; t < 500 && (quiet_irq_n_o & active_irq_n_o) !== 1'b0; t++)
            tick(1);
         `CHK("quiet", n > l, quiet_irq_n_o)
         `CHK("active", n <= l, active_irq_n_o)
         if (c > 0)
            `CHK("window", WU * (l + 1), t)
      end
      `CHK("i2c", 1'b0, two_wire_en_o)
      `CHK("lp", 1'b1, lp_compare_o)
      burst(l + 1, p);
      aut <= 1;
      wait_mode(2'b00);
      `CHK("mav", 1'b1, mav_ready_o)
      `CHK("active_interrupt", 1'b0, active_irq_n_o)
      aut <= 0;
      go(2'b10);
      aut <= 1;
      wait_mode(2'b11);
      `CHK("on", 1'b0, circuits_on_o)
      aut <= 0;
      go(2'b01);
      wait_done;
      `CHK("thr", thr_e, threshold_o)
      reset_pin_n_i <= 0;
      tick(8);
      reset_pin_n_i <= 1;
      wait_done;
      `CHK("thr", 8'h07, threshold_o)
      `CHK("lock", 8'h00, lock_cfg_o)
      for (c = 0; c < 3; c++) begin
         port_select_pin_i <= 0;
         tick(3);
         port_select_pin_i <= 1;
         tick(3);
      end
      lock_wr_i <= 1;
      lock_wdata_i <= 8'h00;
      tick(1);
      lock_wr_i <= 0;
      swr;
      `CHK("spi", 1'b1, four_wire_en_o)
      clk_en_i <= 0;
      req <= 2'b00;
      tick(12);
      `CHK("freeze", 2'b01, mode_o)
      clk_en_i <= 1;
      wait_mode(2'b00);
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
